// ===== rtl/dscg_defs.svh
// constants of the deep-sleep clock gate block: offsets, fields, resets
`ifndef DSCG_DEFS_SVH
`define DSCG_DEFS_SVH

// ---------------------------------------------------------------
// register offsets (low address bits inside the control window)
// ---------------------------------------------------------------
`define DSCG_ADDR_W         12
`define DSCG_OFS_RUN        12'h100
`define DSCG_OFS_SLEEP      12'h110
`define DSCG_OFS_DEEP       12'h120
`define DSCG_OFS_CFG        12'h140
`define DSCG_OFS_STAT       12'h150
`define DSCG_OFS_MASK       12'h154

// ---------------------------------------------------------------
// gating register layout
// ---------------------------------------------------------------
`define DSCG_GATE_RST       32'h0000_0040
`define DSCG_GATE_WMASK     32'h0001_0048
`define DSCG_BIT_ADC        16
`define DSCG_BIT_HIBERNATION 6
`define DSCG_BIT_WATCHDOG   3
`define DSCG_BIT_AUTO_GATE  0
`define DSCG_NUNIT          3
`define DSCG_UNIT_ZERO      3'h0
`define DSCG_WORD_ZERO      32'h0000_0000

// ---------------------------------------------------------------
// bus answers
// ---------------------------------------------------------------
`define DSCG_RESP_OKAY      2'h0
`define DSCG_RESP_SLVERR    2'h2

`endif

// ===== rtl/dscg_pkg.sv
// types shared by the deep-sleep clock gate block
`default_nettype none
package dscg_pkg;
`include "dscg_defs.svh"

    typedef enum logic [1:0]
    {
        DSCG_MODE_RUN   = 2'b00,
        DSCG_MODE_SLEEP = 2'b01,
        DSCG_MODE_DEEP  = 2'b10
    } dscg_mode_t;

    typedef logic [`DSCG_NUNIT-1:0] dscg_units_t;

    typedef struct packed {
        logic [31:0]              run;
        logic [31:0]              sleep;
        logic [31:0]              deep;
        logic                     auto_gate;
        dscg_units_t              stat;
        dscg_units_t              mask;
        dscg_units_t              clk_en;
        logic                     irq;
        logic                     awready;
        logic                     wready;
        logic                     aw_got;
        logic                     w_got;
        logic [`DSCG_ADDR_W-1:0]  awaddr;
        logic [31:0]              wdata;
        logic [3:0]               wstrb;
        logic                     bvalid;
        logic [1:0]               bresp;
        logic                     arready;
        logic                     rvalid;
        logic [31:0]              rdata;
        logic [1:0]               rresp;
    } dscg_top_st_t;

    typedef struct packed {
        dscg_units_t              fault;
    } dscg_flt_st_t;

endpackage
`default_nettype wire

// ===== rtl/dscg_unit_if.sv
// carrier between the gate register file and the fault checker
`timescale 1ns/100ps
`default_nettype none
interface dscg_unit_if;
    import dscg_pkg::*;
    dscg_units_t gate_en;
    dscg_units_t req;
    dscg_units_t fault;
    modport ctrl (output gate_en, output req, input fault);
    modport chk  (input gate_en, input req, output fault);
endinterface
`default_nettype wire

// ===== rtl/dscg_fault.sv
// bus fault detector for accesses to clock-gated units
`timescale 1ns/100ps
`default_nettype none
`include "dscg_defs.svh"
module dscg_fault
    import dscg_pkg::*;
(
    input  wire logic  CLOCK_I,
    input  wire logic  SYS_RST_I,
    dscg_unit_if.chk   u
);

    dscg_flt_st_t st;
    dscg_flt_st_t next_st;

    // ---------------------------------------------------------------
    // fault decision
    // ---------------------------------------------------------------
    always_comb
    begin
        next_st = st;
        // an unclocked unit cannot answer, so the access faults
        next_st.fault = u.req & ~u.gate_en;
    end

    always_ff @(posedge CLOCK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign u.fault = st.fault;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge CLOCK_I);
    endclocking
    default disable iff (SYS_RST_I);

    a_clocked_no_fault: assert property (
        (u.req & u.gate_en) != `DSCG_UNIT_ZERO |=> (u.fault & $past(u.gate_en)) == `DSCG_UNIT_ZERO)
        else $error("fault raised on a clocked unit");

endmodule
`default_nettype wire

// ===== rtl/dscg_top.sv
// deep-sleep clock gate register bank with run/sleep companions, axi4-lite slave
`timescale 1ns/100ps
`default_nettype none
`include "dscg_defs.svh"
module dscg_top
    import dscg_pkg::*;
(
    input  wire logic                     CLOCK_I,
    input  wire logic                     SYS_RST_I,
    input  wire logic [1:0]               MODE_I,
    input  wire logic [`DSCG_NUNIT-1:0]   UNIT_REQ_I,
    output logic      [`DSCG_NUNIT-1:0]   UNIT_CLK_EN_O,
    output logic      [`DSCG_NUNIT-1:0]   UNIT_FAULT_O,
    output logic                          IRQ_O,
    input  wire logic [`DSCG_ADDR_W-1:0]  AXI_AWADDR_I,
    input  wire logic                     AXI_AWVALID_I,
    output logic                          AXI_AWREADY_O,
    input  wire logic [31:0]              AXI_WDATA_I,
    input  wire logic [3:0]               AXI_WSTRB_I,
    input  wire logic                     AXI_WVALID_I,
    output logic                          AXI_WREADY_O,
    output logic [1:0]                    AXI_BRESP_O,
    output logic                          AXI_BVALID_O,
    input  wire logic                     AXI_BREADY_I,
    input  wire logic [`DSCG_ADDR_W-1:0]  AXI_ARADDR_I,
    input  wire logic                     AXI_ARVALID_I,
    output logic                          AXI_ARREADY_O,
    output logic [31:0]                   AXI_RDATA_O,
    output logic [1:0]                    AXI_RRESP_O,
    output logic                          AXI_RVALID_O,
    input  wire logic                     AXI_RREADY_I
);

    dscg_top_st_t st;
    dscg_top_st_t next_st;
    dscg_unit_if  u ();

    // unit order in every vector: 0 converter, 1 hibernation, 2 watchdog
    function automatic dscg_units_t gate_bits(input logic [31:0] r);
        gate_bits = {r[`DSCG_BIT_WATCHDOG], r[`DSCG_BIT_HIBERNATION], r[`DSCG_BIT_ADC]};
    endfunction

    // reserved bits never get stored, so they always read back zero
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] data,
                                          input logic [31:0] bmask);
        logic [31:0] m;
        m = bmask & `DSCG_GATE_WMASK;
        merge = (old & ~m) | (data & m);
    endfunction

    // ---------------------------------------------------------------
    // byte lane mask
    // ---------------------------------------------------------------
    logic [31:0] wbmask;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : g_lane
            assign wbmask[gi*8 +: 8] = {8{st.wstrb[gi]}};
        end
    endgenerate

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb
    begin
        logic        aw_hs;
        logic        w_hs;
        logic        ar_hs;
        dscg_units_t clr;
        aw_hs   = AXI_AWVALID_I && st.awready;
        w_hs    = AXI_WVALID_I && st.wready;
        ar_hs   = AXI_ARVALID_I && st.arready;
        clr     = `DSCG_UNIT_ZERO;
        next_st = st;

        // write channel: address and data in either order
        if (aw_hs)
        begin
            next_st.awready = 1'b0;
            next_st.aw_got  = 1'b1;
            next_st.awaddr  = AXI_AWADDR_I;
        end
        if (w_hs)
        begin
            next_st.wready = 1'b0;
            next_st.w_got  = 1'b1;
            next_st.wdata  = AXI_WDATA_I;
            next_st.wstrb  = AXI_WSTRB_I;
        end
        if (st.aw_got && st.w_got && !st.bvalid)
        begin
            next_st.aw_got = 1'b0;
            next_st.w_got  = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp  = `DSCG_RESP_OKAY;
            case (st.awaddr)
                `DSCG_OFS_RUN:   next_st.run   = merge(st.run, st.wdata, wbmask);
                `DSCG_OFS_SLEEP: next_st.sleep = merge(st.sleep, st.wdata, wbmask);
                `DSCG_OFS_DEEP:  next_st.deep  = merge(st.deep, st.wdata, wbmask);
                `DSCG_OFS_CFG:
                begin
                    if (st.wstrb[0])
                    begin
                        next_st.auto_gate = st.wdata[`DSCG_BIT_AUTO_GATE];
                    end
                end
                `DSCG_OFS_STAT:
                begin
                    if (st.wstrb[0])
                    begin
                        clr = st.wdata[`DSCG_NUNIT-1:0];
                    end
                end
                `DSCG_OFS_MASK:
                begin
                    if (st.wstrb[0])
                    begin
                        next_st.mask = st.wdata[`DSCG_NUNIT-1:0];
                    end
                end
                default:         next_st.bresp = `DSCG_RESP_SLVERR;
            endcase
        end
        if (st.bvalid && AXI_BREADY_I)
        begin
            next_st.bvalid  = 1'b0;
            next_st.awready = 1'b1;
            next_st.wready  = 1'b1;
        end

        // read channel
        if (ar_hs)
        begin
            next_st.arready = 1'b0;
            next_st.rvalid  = 1'b1;
            next_st.rresp   = `DSCG_RESP_OKAY;
            next_st.rdata   = `DSCG_WORD_ZERO;
            case (AXI_ARADDR_I)
                `DSCG_OFS_RUN:   next_st.rdata = st.run;
                `DSCG_OFS_SLEEP: next_st.rdata = st.sleep;
                `DSCG_OFS_DEEP:  next_st.rdata = st.deep;
                `DSCG_OFS_CFG:   next_st.rdata[`DSCG_BIT_AUTO_GATE] = st.auto_gate;
                `DSCG_OFS_STAT:  next_st.rdata[`DSCG_NUNIT-1:0] = st.stat;
                `DSCG_OFS_MASK:  next_st.rdata[`DSCG_NUNIT-1:0] = st.mask;
                default:         next_st.rresp = `DSCG_RESP_SLVERR;
            endcase
        end
        if (st.rvalid && AXI_RREADY_I)
        begin
            next_st.rvalid  = 1'b0;
            next_st.arready = 1'b1;
        end

        // effective unit clocks
        case (MODE_I)
            DSCG_MODE_SLEEP: next_st.clk_en = st.auto_gate ? gate_bits(st.sleep) : gate_bits(st.run);
            DSCG_MODE_DEEP:  next_st.clk_en = st.auto_gate ? gate_bits(st.deep) : gate_bits(st.run);
            default:         next_st.clk_en = gate_bits(st.run);
        endcase

        // a fault in the same cycle as its clear is kept
        next_st.stat = (st.stat & ~clr) | u.fault;
        next_st.irq  = |(next_st.stat & next_st.mask);
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge CLOCK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            st         <= '0;
            st.run     <= `DSCG_GATE_RST;
            st.sleep   <= `DSCG_GATE_RST;
            st.deep    <= `DSCG_GATE_RST;
            st.awready <= 1'b1;
            st.wready  <= 1'b1;
            st.arready <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ---------------------------------------------------------------
    // fault checker and outputs
    // ---------------------------------------------------------------
    assign u.gate_en = st.clk_en;
    assign u.req     = UNIT_REQ_I;

    dscg_fault u_fault
    (
        .CLOCK_I   (CLOCK_I),
        .SYS_RST_I (SYS_RST_I),
        .u         (u.chk)
    );

    assign UNIT_CLK_EN_O = st.clk_en;
    assign UNIT_FAULT_O  = u.fault;
    assign IRQ_O         = st.irq;
    assign AXI_AWREADY_O = st.awready;
    assign AXI_WREADY_O  = st.wready;
    assign AXI_BRESP_O   = st.bresp;
    assign AXI_BVALID_O  = st.bvalid;
    assign AXI_ARREADY_O = st.arready;
    assign AXI_RDATA_O   = st.rdata;
    assign AXI_RRESP_O   = st.rresp;
    assign AXI_RVALID_O  = st.rvalid;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    logic wr_fire;
    assign wr_fire = st.aw_got && st.w_got && !st.bvalid;

    // must stay live while reset is high, so the module default is overridden
    a_reset_value: assert property (@(posedge CLOCK_I) disable iff (1'b0)
        SYS_RST_I |=> (st.deep == `DSCG_GATE_RST) || SYS_RST_I)
        else $error("deep gate register not at reset value");

    default clocking cb @(posedge CLOCK_I);
    endclocking
    default disable iff (SYS_RST_I);

    // the first edge out of reset still shows the all-off reset enables
    a_deep_follows_reg: assert property (
        (!$past(SYS_RST_I) && MODE_I == DSCG_MODE_DEEP && st.auto_gate)
        |=> UNIT_CLK_EN_O == gate_bits($past(st.deep)))
        else $error("unit clocks do not follow deep gate register");

    a_gated_adc_fault: assert property (
        (UNIT_REQ_I[0] && !UNIT_CLK_EN_O[0]) |=> UNIT_FAULT_O[0] ##1 st.stat[0])
        else $error("gated converter access did not fault");

    a_adc_bit_rw: assert property (
        (wr_fire && st.awaddr == `DSCG_OFS_DEEP && st.wstrb[2])
        |=> st.deep[`DSCG_BIT_ADC] == $past(st.wdata[`DSCG_BIT_ADC]))
        else $error("converter gate bit not written");

    a_hibern_bit_rw: assert property (
        (wr_fire && st.awaddr == `DSCG_OFS_DEEP && st.wstrb[0])
        |=> st.deep[`DSCG_BIT_HIBERNATION] == $past(st.wdata[`DSCG_BIT_HIBERNATION]))
        else $error("hibernation gate bit not written");

    a_watchdog_bit_rw: assert property (
        (wr_fire && st.awaddr == `DSCG_OFS_DEEP && st.wstrb[0])
        |=> st.deep[`DSCG_BIT_WATCHDOG] == $past(st.wdata[`DSCG_BIT_WATCHDOG]))
        else $error("watchdog gate bit not written");

    a_gated_watchdog_fault: assert property (
        (UNIT_REQ_I[2] && !UNIT_CLK_EN_O[2]) |=> UNIT_FAULT_O[2])
        else $error("gated watchdog access did not fault");

    a_gated_hibern_fault: assert property (
        (UNIT_REQ_I[1] && !UNIT_CLK_EN_O[1]) |=> UNIT_FAULT_O[1])
        else $error("gated hibernation access did not fault");

    a_irq_level: assert property (
        IRQ_O == |(st.stat & st.mask))
        else $error("interrupt level does not match masked status");

    a_reserved_zero: assert property (
        ((st.deep | st.run | st.sleep) & ~`DSCG_GATE_WMASK) == `DSCG_WORD_ZERO)
        else $error("reserved gate bits not zero");

    a_sleep_select: assert property (
        (!$past(SYS_RST_I) && MODE_I == DSCG_MODE_SLEEP && st.auto_gate)
        |=> UNIT_CLK_EN_O == gate_bits($past(st.sleep)))
        else $error("sleep register not applied in sleep");

    a_no_auto_run: assert property (
        (!$past(SYS_RST_I) && !st.auto_gate) |=> UNIT_CLK_EN_O == gate_bits($past(st.run)))
        else $error("sleep registers applied without automatic gating");

    a_deep_read: assert property (
        (AXI_ARVALID_I && AXI_ARREADY_O && AXI_ARADDR_I == `DSCG_OFS_DEEP)
        |=> AXI_RVALID_O && AXI_RDATA_O == $past(st.deep) && AXI_RRESP_O == `DSCG_RESP_OKAY)
        else $error("deep gate register read wrong");

    a_deep_decode: assert property (
        !(wr_fire && st.awaddr == `DSCG_OFS_DEEP) |=> st.deep == $past(st.deep))
        else $error("deep gate register changed by another address");

    a_run_mode_run: assert property (
        (!$past(SYS_RST_I) && MODE_I == DSCG_MODE_RUN)
        |=> UNIT_CLK_EN_O == gate_bits($past(st.run)))
        else $error("run register not applied in run mode");

endmodule
`default_nettype wire

// ===== dv/dscg_sw_model.sv
// software-side bus master model for the clock gate register bank
`timescale 1ns/100ps
`default_nettype none
`include "dscg_defs.svh"
module dscg_sw_model
    import dscg_pkg::*;
(
    input  wire logic                    clock_i,
    output var  logic [`DSCG_ADDR_W-1:0] awaddr_o,
    output var  logic                    awvalid_o,
    input  wire logic                    awready_i,
    output var  logic [31:0]             wdata_o,
    output var  logic [3:0]              wstrb_o,
    output var  logic                    wvalid_o,
    input  wire logic                    wready_i,
    input  wire logic [1:0]              bresp_i,
    input  wire logic                    bvalid_i,
    output var  logic                    bready_o,
    output var  logic [`DSCG_ADDR_W-1:0] araddr_o,
    output var  logic                    arvalid_o,
    input  wire logic                    arready_i,
    input  wire logic [31:0]             rdata_i,
    input  wire logic [1:0]              rresp_i,
    input  wire logic                    rvalid_i,
    output var  logic                    rready_o
);
    initial
    begin
        {awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o, bready_o} = '0;
        {araddr_o, arvalid_o, rready_o} = '0;
    end

    // -----------------------------------------------------------
    // bus cycles
    // -----------------------------------------------------------
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                          output logic [1:0] r);
        @(posedge clock_i);
        awaddr_o  <= a;
        wdata_o   <= d;
        wstrb_o   <= s;
        awvalid_o <= 1'b1;
        wvalid_o  <= 1'b1;
        bready_o  <= 1'b1;
        do
        begin
            @(posedge clock_i);
            if (awvalid_o && awready_i)
                awvalid_o <= 1'b0;
            // released data lines must not keep a plausible value
            if (wvalid_o && wready_i)
                wdata_o <= ~wdata_o;
            if (wvalid_o && wready_i)
                wvalid_o <= 1'b0;
        end
        while (!bvalid_i);
        r = bresp_i;
        bready_o <= 1'b0;
    endtask

    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clock_i);
        araddr_o  <= a;
        arvalid_o <= 1'b1;
        rready_o  <= 1'b1;
        do
        begin
            @(posedge clock_i);
            if (arvalid_o && arready_i)
                arvalid_o <= 1'b0;
        end
        while (!rvalid_i);
        d = rdata_i;
        r = rresp_i;
        rready_o <= 1'b0;
    endtask

    task automatic sw_rmw(input logic [11:0] a, input logic [31:0] set_bits);
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(a, d, r);
        axi_wr(a, d | set_bits, 4'hf, r); // reserved bits written back as read
    endtask
endmodule
`default_nettype wire

// ===== dv/testbench.sv
// self-checking bench for the deep-sleep clock gate register bank
`timescale 1ns/100ps
`default_nettype none
`include "dscg_defs.svh"
module testbench
    import dscg_pkg::*;
;
    logic        clock = 1'b0;
    logic        rst   = 1'b1;
    logic [1:0]  mode  = 2'h0;
    logic [2:0]  req   = 3'h0;
    wire  logic [2:0]  en, flt;
    wire  logic        irq, awv, awr, wv, wr_rdy, bv, br, arv, arr, rv, rr;
    wire  logic [11:0] awa, ara;
    wire  logic [31:0] wd, rdat;
    wire  logic [3:0]  ws;
    wire  logic [1:0]  bres, rres;
    int          mismatches = 0;
    int          n_checks   = 0;

    always #4 clock = ~clock;

    dscg_top dut (.CLOCK_I(clock), .SYS_RST_I(rst), .MODE_I(mode), .UNIT_REQ_I(req),
        .UNIT_CLK_EN_O(en), .UNIT_FAULT_O(flt), .IRQ_O(irq),
        .AXI_AWADDR_I(awa), .AXI_AWVALID_I(awv), .AXI_AWREADY_O(awr),
        .AXI_WDATA_I(wd), .AXI_WSTRB_I(ws), .AXI_WVALID_I(wv), .AXI_WREADY_O(wr_rdy),
        .AXI_BRESP_O(bres), .AXI_BVALID_O(bv), .AXI_BREADY_I(br),
        .AXI_ARADDR_I(ara), .AXI_ARVALID_I(arv), .AXI_ARREADY_O(arr),
        .AXI_RDATA_O(rdat), .AXI_RRESP_O(rres), .AXI_RVALID_O(rv), .AXI_RREADY_I(rr));

    dscg_sw_model sw (.clock_i(clock), .awaddr_o(awa), .awvalid_o(awv), .awready_i(awr),
        .wdata_o(wd), .wstrb_o(ws), .wvalid_o(wv), .wready_i(wr_rdy), .bresp_i(bres),
        .bvalid_i(bv), .bready_o(br), .araddr_o(ara), .arvalid_o(arv), .arready_i(arr),
        .rdata_i(rdat), .rresp_i(rres), .rvalid_i(rv), .rready_o(rr));

    // -----------------------------------------------------------
    // helpers
    // -----------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        logic [1:0] r;
        sw.axi_wr(a, d, s, r);
        chk("bresp", {30'h0, er}, {30'h0, r});
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0]  r;
        sw.axi_rd(a, d, r);
        chk("rdata", ed, d);
        chk("rresp", {30'h0, er}, {30'h0, r});
    endtask

    // enables lag mode and register changes, so let them settle
    task automatic en_is(input logic [2:0] e);
        repeat (3) @(posedge clock);
        #1 chk("clk_en", {29'h0, e}, {29'h0, en});
    endtask

    task automatic pulse(input logic [2:0] r, input logic [2:0] ef, input logic ei);
        @(posedge clock);
        req <= r;
        @(posedge clock);
        req <= 3'h0;
        #1 chk("fault", {29'h0, ef}, {29'h0, flt});
        @(posedge clock);
        #1 chk("irq", {31'h0, ei}, {31'h0, irq});
    endtask

    // -----------------------------------------------------------
    // scenarios
    // -----------------------------------------------------------
    task automatic t_reset;
        rd(12'h100, 32'h0000_0040, 2'h0);
        rd(12'h110, 32'h0000_0040, 2'h0);
        rd(12'h120, 32'h0000_0040, 2'h0);
        rd(12'h140, 32'h0, 2'h0);
        rd(12'h150, 32'h0, 2'h0);
        rd(12'h154, 32'h0, 2'h0);
        en_is(3'b010);
    endtask

    task automatic t_fields;
        wr(12'h120, 32'hffff_ffff, 4'hf, 2'h0);
        rd(12'h120, 32'h0001_0048, 2'h0);
        wr(12'h120, 32'h0, 4'h1, 2'h0);
        rd(12'h120, 32'h0001_0000, 2'h0);
        wr(12'h124, 32'hffff_ffff, 4'hf, 2'h2);
        rd(12'h124, 32'h0, 2'h2);
        rd(12'h120, 32'h0001_0000, 2'h0);
    endtask

    task automatic t_modes;
        wr(12'h120, 32'h0001_0008, 4'hf, 2'h0);
        wr(12'h110, 32'h0000_0048, 4'hf, 2'h0);
        mode <= 2'h2;
        en_is(3'b010);
        sw.sw_rmw(12'h140, 32'h1);
        en_is(3'b101);
        mode <= 2'h1;
        en_is(3'b110);
        mode <= 2'h0;
        en_is(3'b010);
        mode <= 2'h3;
        en_is(3'b010);
        mode <= 2'h0;
    endtask

    task automatic t_fault;
        pulse(3'b001, 3'b001, 1'b0);
        wr(12'h154, 32'h4, 4'hf, 2'h0);
        pulse(3'b110, 3'b100, 1'b1);
        rd(12'h150, 32'h5, 2'h0);
        wr(12'h150, 32'h4, 4'hf, 2'h0);
        repeat (2) @(posedge clock);
        #1 chk("irq", 32'h0, {31'h0, irq});
        rd(12'h150, 32'h1, 2'h0);
    endtask

    // -----------------------------------------------------------
    // run control
    // -----------------------------------------------------------
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        t_reset();
        t_fields();
        t_modes();
        t_fault();
        end_of_test();
    end

    // the whole run needs well under a thousand cycles
    initial
    begin
        repeat (20000) @(posedge clock);
        mismatches++;
        end_of_test();
    end
endmodule
`default_nettype wire
